//--- hdl/cfg_access.v
`timescale 1ns/1ps
`include "cfg_access_consts.vh"

module cfg_access (
    input wire ref_clk_i, // 100 MHz tile clock
    input wire reset_n_i, // Async reset, active low
    input wire [1:0] bank_i, // Bank of incoming message, from its destination
    input wire rx_valid_i, // Incoming token present
    input wire rx_ctrl_i, // Incoming token is a control token
    input wire [7:0] rx_data_i, // Incoming token value
    output reg rx_ready_o, // Handler accepts a token
    output reg tx_valid_o, // Outgoing token present
    output reg tx_ctrl_o, // Outgoing token is a control token
    output reg [7:0] tx_data_o, // Outgoing token value
    output reg [23:0] tx_dest_o, // Reply channel-end of outgoing token
    input wire tx_ready_i, // Interconnect takes outgoing token
    input wire ps_req_i, // Status access request pulse
    input wire ps_write_i, // Status access is a write
    input wire [31:0] ps_res_id_i, // Status resource identifier
    input wire [31:0] ps_wdata_i, // Status write word
    output reg ps_ack_o, // Status access done pulse
    output reg ps_err_o, // Status access refused
    output reg [31:0] ps_rdata_o // Status read word
);

    localparam S_IDLE = 3'd0;
    localparam S_ID = 3'd1;
    localparam S_REG = 3'd2;
    localparam S_DATA = 3'd3;
    localparam S_END = 3'd4;
    localparam S_RESP = 3'd5;

    reg [2:0] state_reg;
    reg [1:0] cnt_reg;
    reg [1:0] bank_reg;
    reg wr_reg;
    reg err_reg;
    reg [23:0] id_reg;
    reg [15:0] regnum_reg;
    reg [31:0] data_reg;
    reg ok_reg;
    reg [2:0] idx_reg;
    reg [31:0] cfg_mem [0:`CFG_WORDS-1];
    reg [31:0] ps_mem [0:15];
    integer i;
    integer j;

    wire take = rx_valid_i & rx_ready_o;
    wire send = ~tx_valid_o | tx_ready_i;

    // Byte shift, most significant byte arrives first
    function [31:0] shift_in;
        input [31:0] old;
        input [7:0] b;
        begin
            shift_in = {old[23:0], b};
        end
    endfunction

    // Register exists in an implemented bank
    function reg_ok;
        input [1:0] bank;
        input [15:0] num;
        begin
            reg_ok = (bank != 2'h3) && (num < `BANK_REGS);
        end
    endfunction

    // Word index into the configuration store
    function [5:0] cfg_index;
        input [1:0] bank;
        input [15:0] num;
        begin
            cfg_index = {bank, num[`BANK_IDX_W-1:0]};
        end
    endfunction

    // Field values with the next byte shifted in, cut to field width
    wire [31:0] id_shift = shift_in({8'h00, id_reg}, rx_data_i);
    wire [31:0] reg_shift = shift_in({16'h0000, regnum_reg}, rx_data_i);

    // Completion decisions for the current message
    wire fin_ok = ~err_reg && reg_ok(bank_reg, regnum_reg);
    wire quiet = wr_reg && (id_reg[7:0] == `ID_NOREPLY);
    wire [5:0] widx = cfg_index(bank_reg, regnum_reg);

    // Message parser and reply sequencer
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= S_IDLE;
            cnt_reg <= 2'h0;
            bank_reg <= 2'h0;
            wr_reg <= 1'b0;
            err_reg <= 1'b0;
            id_reg <= 24'h00_0000;
            regnum_reg <= 16'h0000;
            data_reg <= 32'h0000_0000;
            ok_reg <= 1'b0;
            idx_reg <= 3'd0;
            rx_ready_o <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_ctrl_o <= 1'b0;
            tx_data_o <= 8'h00;
            tx_dest_o <= 24'h00_0000;
            for (i = 0; i < `CFG_WORDS; i = i + 1)
                cfg_mem[i] <= 32'h0000_0000;
        end else begin
            rx_ready_o <= (state_reg != S_RESP);
            if (send)
                tx_valid_o <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (take && rx_ctrl_i) begin
                        wr_reg <= (rx_data_i == `TOK_WRITE);
                        err_reg <= (rx_data_i != `TOK_WRITE) && (rx_data_i != `TOK_READ);
                        bank_reg <= bank_i;
                        cnt_reg <= 2'h0;
                        id_reg <= 24'h00_0000;
                        regnum_reg <= 16'h0000;
                        state_reg <= S_ID;
                    end
                end
                S_ID, S_REG, S_DATA: begin
                    if (take && rx_ctrl_i) begin
                        // Early control token: malformed message
                        err_reg <= 1'b1;
                        if (rx_data_i == `TOK_END) begin
                            ok_reg <= 1'b0;
                            idx_reg <= 3'd0;
                            rx_ready_o <= 1'b0;
                            state_reg <= quiet ? S_IDLE : S_RESP;
                        end
                    end else if (take) begin
                        cnt_reg <= cnt_reg + 2'h1;
                        if (state_reg == S_ID) begin
                            id_reg <= id_shift[23:0];
                            if (cnt_reg == `ID_LAST) begin
                                cnt_reg <= 2'h0;
                                state_reg <= S_REG;
                            end
                        end else if (state_reg == S_REG) begin
                            regnum_reg <= reg_shift[15:0];
                            if (cnt_reg == `REG_LAST) begin
                                cnt_reg <= 2'h0;
                                state_reg <= wr_reg ? S_DATA : S_END;
                            end
                        end else begin
                            data_reg <= shift_in(data_reg, rx_data_i);
                            if (cnt_reg == `DATA_LAST)
                                state_reg <= S_END;
                        end
                    end
                end
                S_END: begin
                    if (take && !rx_ctrl_i) begin
                        err_reg <= 1'b1;
                    end else if (take && rx_data_i != `TOK_END) begin
                        err_reg <= 1'b1;
                    end else if (take) begin
                        // Complete message: perform access
                        ok_reg <= fin_ok;
                        if (fin_ok && wr_reg)
                            cfg_mem[widx] <= data_reg;
                        if (fin_ok && !wr_reg)
                            data_reg <= cfg_mem[widx];
                        idx_reg <= 3'd0;
                        rx_ready_o <= 1'b0;
                        state_reg <= quiet ? S_IDLE : S_RESP;
                    end
                end
                S_RESP: begin
                    rx_ready_o <= 1'b0;
                    if (send) begin
                        tx_valid_o <= 1'b1;
                        tx_dest_o <= id_reg;
                        if (idx_reg == 3'd0) begin
                            tx_ctrl_o <= 1'b1;
                            tx_data_o <= ok_reg ? `TOK_ACK : `TOK_NACK;
                            idx_reg <= (ok_reg && !wr_reg) ? 3'd1 : 3'd5;
                        end else if (idx_reg != 3'd5) begin
                            tx_ctrl_o <= 1'b0;
                            tx_data_o <= data_reg[31:24];
                            data_reg <= {data_reg[23:0], 8'h00};
                            idx_reg <= idx_reg + 3'd1;
                        end else begin
                            tx_ctrl_o <= 1'b1;
                            tx_data_o <= `TOK_END;
                            rx_ready_o <= 1'b1;
                            state_reg <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Processor-status access by resource identifier
    wire ps_hit = (ps_res_id_i[7:0] == `PS_RES_TYPE) && (ps_res_id_i[31:8] < `PS_REGS);

    // Status store with a one-cycle answer
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ps_ack_o <= 1'b0;
            ps_err_o <= 1'b0;
            ps_rdata_o <= 32'h0000_0000;
            for (j = 0; j < 16; j = j + 1)
                ps_mem[j] <= 32'h0000_0000;
        end else begin
            ps_ack_o <= ps_req_i;
            ps_err_o <= ps_req_i && !ps_hit;
            if (ps_req_i && ps_hit && ps_write_i)
                ps_mem[ps_res_id_i[11:8]] <= ps_wdata_i;
            if (ps_req_i && ps_hit && !ps_write_i)
                ps_rdata_o <= ps_mem[ps_res_id_i[11:8]];
            else if (ps_req_i)
                ps_rdata_o <= 32'h0000_0000;
        end
    end

endmodule

//--- hdl/cfg_access_consts.vh
// Function
// - Write: token 192, id, register, data, token 1
// - Write reply: tokens 3,1 success; 4,1 failure
// - Read: token 193, id, register, token 1
// - Tile/node read reply: 3, data word, 1
// - Replies go to carried 24-bit channel-end
// - Write id low byte all ones: no reply
// - Multi-byte fields travel most significant first
// - Peripheral read reply: 3, data, 1
// - Status resource id is register<<8 OR 0x0B
// - Status read/write moves one full word
`ifndef CFG_ACCESS_CONSTS_VH
`define CFG_ACCESS_CONSTS_VH

// Control token values
`define TOK_WRITE 8'hC0
`define TOK_READ 8'hC1
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NACK 8'h04

// Reply suppression marker in id low byte
`define ID_NOREPLY 8'hFF

// Bank selection codes
`define BANK_TILE 2'h0
`define BANK_NODE 2'h1
`define BANK_PERIPH 2'h2

// Registers implemented per bank and status registers
`define BANK_REGS 16'h0010
`define BANK_IDX_W 4
`define CFG_WORDS 48
`define PS_REGS 24'h00_0010

// Status resource type in low byte
`define PS_RES_TYPE 8'h0B

// Field byte counts, minus one
`define ID_LAST 2'h2
`define REG_LAST 2'h1
`define DATA_LAST 2'h3

`endif

//--- sim/reply_sink.sv
`timescale 1ns/1ps
module reply_sink (
    input wire ref_clk_i, // Tile clock
    output reg ready_o // Takes reply tokens
);
    // Ready or stalled at random, one decision a cycle
    initial begin
        ready_o = 1'b0;
        forever begin
            @(posedge ref_clk_i);
            #1 ready_o = ($urandom % 3) != 0;
        end
    end
endmodule

//--- sim/cfg_access_props.sv
`timescale 1ns/1ps
module cfg_access_props (
    input wire ref_clk_i, // Clock
    input wire reset_n_i, // Reset
    input wire rx_valid_i, // Token in
    input wire rx_ctrl_i, // Control in
    input wire [7:0] rx_data_i, // Value in
    input wire rx_ready_o, // Taken
    input wire tx_valid_o, // Token out
    input wire tx_ctrl_o, // Control out
    input wire [7:0] tx_data_o, // Value out
    input wire [23:0] tx_dest_o, // Reply end
    input wire tx_ready_i, // Sink ready
    input wire ps_req_i, // Status req
    input wire [31:0] ps_res_id_i, // Status id
    input wire ps_ack_o, // Status ack
    input wire ps_err_o, // Status error
    input wire [31:0] ps_rdata_o // Status word
);
    // Reply stream, incoming stream and status port relations
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    ack_pulse_a: assert property (ps_req_i |=> ps_ack_o) else $error("status ack late");
    ack_cause_a: assert property (ps_ack_o |-> $past(ps_req_i)) else $error("stray ack");
    type_err_a: assert property (ps_req_i && ps_res_id_i[7:0] != 8'h0B |=> ps_err_o)
        else $error("bad type taken");
    index_err_a: assert property (ps_req_i && ps_res_id_i[31:8] > 24'h00_000F
        |=> ps_err_o) else $error("bad index taken");
    err_word_a: assert property (ps_ack_o && ps_err_o |-> ps_rdata_o == 32'h0000_0000)
        else $error("word on error");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o
        && $stable({tx_ctrl_o, tx_data_o, tx_dest_o})) else $error("reply token moved");
    reply_ctrl_a: assert property (tx_valid_o && tx_ctrl_o
        |-> tx_data_o inside {8'h03, 8'h04, 8'h01}) else $error("bad reply control");
    rx_close_a: assert property ($fell(rx_ready_o)
        |-> $past(rx_valid_i && rx_ctrl_i && rx_data_i == 8'h01)) else $error("stall without close");
endmodule
bind cfg_access cfg_access_props props_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .rx_valid_i(rx_valid_i), .rx_ctrl_i(rx_ctrl_i), .rx_data_i(rx_data_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_ctrl_o(tx_ctrl_o),
    .tx_data_o(tx_data_o), .tx_dest_o(tx_dest_o), .tx_ready_i(tx_ready_i),
    .ps_req_i(ps_req_i), .ps_res_id_i(ps_res_id_i), .ps_ack_o(ps_ack_o),
    .ps_err_o(ps_err_o), .ps_rdata_o(ps_rdata_o));

//--- sim/cfg_access_tb.sv
`timescale 1ns/1ps
`include "cfg_access_consts.vh"
module cfg_access_tb;
    reg ref_clk_i, reset_n_i, rx_valid_i, rx_ctrl_i, ps_req_i, ps_write_i;
    reg [1:0] bank_i;
    reg [7:0] rx_data_i;
    reg [31:0] ps_res_id_i, ps_wdata_i, d, mem [0:63];
    reg [23:0] id;
    reg [15:0] r;
    wire rx_ready_o, tx_valid_o, tx_ctrl_o, tx_ready_i, ps_ack_o, ps_err_o;
    wire [7:0] tx_data_o;
    wire [23:0] tx_dest_o;
    wire [31:0] ps_rdata_o;
    logic [32:0] rq[$], pq[$];
    int miscompares = 0, samples_checked = 0, i, k;
    cfg_access dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bank_i(bank_i),
        .rx_valid_i(rx_valid_i), .rx_ctrl_i(rx_ctrl_i), .rx_data_i(rx_data_i),
        .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_ctrl_o(tx_ctrl_o),
        .tx_data_o(tx_data_o), .tx_dest_o(tx_dest_o), .tx_ready_i(tx_ready_i),
        .ps_req_i(ps_req_i), .ps_write_i(ps_write_i), .ps_res_id_i(ps_res_id_i),
        .ps_wdata_i(ps_wdata_i), .ps_ack_o(ps_ack_o), .ps_err_o(ps_err_o),
        .ps_rdata_o(ps_rdata_o));
    reply_sink sink_u (.ref_clk_i(ref_clk_i), .ready_o(tx_ready_i));
    // Clock
    initial begin
        ref_clk_i = 0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task chk(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One token, held until taken
    task tok(input logic c, input logic [7:0] v);
        rx_valid_i = 1;
        rx_ctrl_i = c;
        rx_data_i = v;
        do @(posedge ref_clk_i); while (rx_ready_o !== 1'b1);
        #1;
    endtask
    // Whole message plus its expected reply
    task msg(input logic [7:0] lead, input logic [1:0] b, input logic [15:0] rn);
        logic wr, ok;
        logic [5:0] a;
        wr = lead == `TOK_WRITE;
        ok = (wr || lead == `TOK_READ) && b != 2'h3 && rn < 16;
        a = {b, rn[3:0]};
        bank_i = b;
        tok(1, lead);
        for (i = 16; i >= 0; i -= 8) tok(0, id[i +: 8]);
        for (i = 8; i >= 0; i -= 8) tok(0, rn[i +: 8]);
        if (wr) for (i = 24; i >= 0; i -= 8) tok(0, d[i +: 8]);
        tok(1, `TOK_END);
        rx_valid_i = 0;
        if (wr && ok) mem[a] = d;
        if (!(wr && id[7:0] == `ID_NOREPLY)) begin
            rq.push_back({id, 1'b1, ok ? `TOK_ACK : `TOK_NACK});
            if (ok && !wr) for (i = 24; i >= 0; i -= 8) rq.push_back({id, 1'b0, mem[a][i +: 8]});
            rq.push_back({id, 1'b1, `TOK_END});
        end
        // Let an edge pass before the next lead token
        @(posedge ref_clk_i);
        #1;
    endtask
    // Status access; request left high for back to back use
    task ps(input logic w, input logic [31:0] rid);
        logic bad;
        bad = rid[7:0] != `PS_RES_TYPE || rid[31:8] > 15;
        ps_req_i = 1;
        ps_write_i = w;
        ps_res_id_i = rid;
        ps_wdata_i = d;
        if (w && !bad) mem[48 + rid[11:8]] = d;
        pq.push_back({bad, (w || bad) ? 32'h0000_0000 : mem[48 + rid[11:8]]});
        @(posedge ref_clk_i);
        #1;
    endtask
    // Results against the oldest notes
    always @(posedge ref_clk_i) begin
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
            chk({tx_dest_o, tx_ctrl_o, tx_data_o}, rq.size() ? rq.pop_front() : 'x);
        if (ps_ack_o === 1'b1) chk({ps_err_o, ps_rdata_o}, pq.size() ? pq.pop_front() : 'x);
    end
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        conclude;
    end
    // Main sequence
    initial begin
        void'($urandom(32'hb54f50da));
        {reset_n_i, rx_valid_i, rx_ctrl_i, ps_req_i, ps_write_i, bank_i, rx_data_i} = 0;
        {ps_res_id_i, ps_wdata_i, id, d, r} = 0;
        for (i = 0; i < 64; i++) mem[i] = 0;
        repeat (2) @(posedge ref_clk_i);
        #1 reset_n_i = 1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        for (k = 0; k < 9; k++) begin
            id = $urandom;
            id[0] = id[0] & ~&id[7:1];
            d = $urandom;
            r = $urandom % 16;
            msg(`TOK_WRITE, 2'(k % 3), r);
            msg(`TOK_READ, 2'(k % 3), r);
        end
        id[7:0] = `ID_NOREPLY;
        d = $urandom;
        msg(`TOK_WRITE, 2'h0, 16'h0005);
        msg(`TOK_WRITE, 2'h1, 16'h0010);
        id[7:0] = 8'h00;
        msg(`TOK_READ, 2'h0, 16'h0005);
        msg(`TOK_READ, 2'h1, 16'h0010);
        msg(`TOK_WRITE, 2'h3, 16'h0000);
        msg(8'h05, 2'h0, 16'h0000);
        for (k = 0; k < 4; k++) begin
            d = $urandom;
            r = $urandom % 16;
            ps(1, {20'h0_0000, r[3:0], `PS_RES_TYPE});
            ps(0, {20'h0_0000, r[3:0], `PS_RES_TYPE});
        end
        ps(0, 32'h0000_0103);
        ps(1, 32'h0000_100B);
        ps_req_i = 0;
        for (k = 0; k < 500 && rq.size() + pq.size() > 0; k++) @(posedge ref_clk_i);
        chk(rq.size() + pq.size(), 0);
        conclude;
    end
endmodule
